// ==== hdl/nrzw_pkg.sv ====
/*
 * Package for the NRZ tape write formatter: register map, field
 * positions, reset values, sequencing counts and the character carrier.
 * Assumes a single 20 MHz core clock domain.
 */
package nrzw_pkg;

   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [3:0] NRZW_OFF_CTRL   = 4'h0;
   localparam logic [3:0] NRZW_OFF_FUNC   = 4'h4;
   localparam logic [3:0] NRZW_OFF_FRAME  = 4'h8;
   localparam logic [3:0] NRZW_OFF_STATUS = 4'hC;

   // ***************************************************************
   // Fields and reset values
   // ***************************************************************
   localparam int         NRZW_CTRL_ODD_BIT = 0;
   localparam logic       NRZW_CTRL_ODD_RST = 1'b1;
   localparam logic [7:0] NRZW_FN_WRITE_DATA = 8'h01;
   localparam logic [7:0] NRZW_FN_WRITE_MARK = 8'h02;
   localparam logic [7:0] NRZW_CRC_POLY      = 8'h1D;

   // ***************************************************************
   // Post-record sequencing
   // ***************************************************************
   localparam logic [3:0] NRZW_POST_PRESET = 4'h8;
   localparam logic [3:0] NRZW_POST_CRC    = 4'hB;
   localparam logic [3:0] NRZW_POST_LRC    = 4'hF;
   localparam logic [3:0] NRZW_POST_STOP   = 4'h0;

   // ***************************************************************
   // Tape mark character (octal 23) and its force groups
   // ***************************************************************
   localparam logic [8:0] NRZW_TM_CHAR      = 9'h013;
   localparam logic [8:0] NRZW_FORCE_MAIN   = 9'h010;
   localparam logic [8:0] NRZW_FORCE_SEV_HI = 9'h002;
   localparam logic [8:0] NRZW_FORCE_SEV_LO = 9'h001;

   typedef struct packed {
      logic       parity;
      logic [7:0] data;
   } nrzw_char_s;

   typedef struct packed {
      logic mark_force_main;
      logic mark_force_seven_track_hi;
      logic mark_force_seven_track_lo;
   } nrzw_force_s;

endpackage

// ==== hdl/nrzw_formatter.sv ====
/*
 * NRZ write formatter: parity, write buffer, cyclic check generator,
 * post-record check sequencing and tape mark forcing.
 * Assumes transport_write_clock and run arrive from outside the clock
 * domain; the register master follows the plain strobe protocol.
 */
//
// Function
// - Append software-selected odd/even vertical parity.
// - Load pulse captures multiplexer into write buffer.
// - Write-data code presents write and forward commands.
// - Run gives drive-set pulse setting record-active.
// - Start pulse; transport moves tape, gates heads.
// - Write clock gives request, load, record pulses.
// - Pulses continue until frame counter counts down to zero.
// - Check generator shifts and XORs every loaded data character.
// - Counter preset 8; strobes at 11, 15.
// - Post-record counter stops on wrap to zero.
// - Each strobe releases one load and record pulse.
// - Cyclic strobe selects check character into buffer.
// - Longitudinal strobe clears buffer, forwarded to transport.
// - Tape mark clears buffer and forces mark lines.
// - Forced tape mark character is code 23.
// - No cyclic check character after tape mark.
// - Longitudinal strobe still follows tape mark normally.
module nrzw_formatter
   import nrzw_pkg::*;
#(
   parameter int FRAME_W = 16
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               reset,
   // Register port
   input  wire logic [3:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   // Upstream byte assembler
   input  wire logic [7:0]         assembled_write_char,
   output logic                    next_char_request,
   // Controller
   input  wire logic               run,
   // Transport slave bus
   input  wire logic               transport_write_clock,
   output logic      [8:0]         slave_write_lines,
   output logic                    record_pulse,
   output logic                    write_cmd,
   output logic                    forward_direction_cmd,
   output logic                    transport_start_pulse,
   output logic                    longitudinal_check_strobe
);

   generate
      if (FRAME_W < 1 || FRAME_W > 32) begin : g_bad_w
         $error("FRAME_W must lie in 1..32");
      end
   endgenerate

   // ***************************************************************
   // Input synchronisers (write clock, run)
   // ***************************************************************
   logic [1:0] s1_q, s2_q, s3_q, acc_q, acc_d, rise;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_comb begin
            acc_d[gi] = acc_q[gi];
            rise[gi]  = 1'b0;
            if (s2_q[gi] == s3_q[gi] && s3_q[gi] != acc_q[gi]) begin
               acc_d[gi] = s3_q[gi];
               rise[gi]  = s3_q[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         s1_q  <= 2'h0;
         s2_q  <= 2'h0;
         s3_q  <= 2'h0;
         acc_q <= 2'h0;
      end else begin
         s1_q  <= {run, transport_write_clock};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         acc_q <= acc_d;
      end
   end

   logic wclk_rise, run_rise;
   assign wclk_rise = rise[0];
   assign run_rise  = rise[1];

   // ***************************************************************
   // Parity and check character
   // ***************************************************************
   logic                par_odd_q, par_odd_d;
   logic [7:0]          crc_q, crc_d;
   nrzw_char_s          data_char, crc_char;

   function automatic logic par_of(input logic [7:0] v, input logic odd);
      par_of = (^v) ^ odd;
   endfunction

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] v);
      logic [7:0] t;
      t        = c ^ v;
      crc_step = {t[6:0], 1'b0} ^ (t[7] ? NRZW_CRC_POLY : 8'h00);
   endfunction

   always_comb begin
      data_char.data   = assembled_write_char;
      data_char.parity = par_of(assembled_write_char, par_odd_q);
      crc_char.data    = crc_q;
      crc_char.parity  = par_of(crc_q, par_odd_q);
   end

   // ***************************************************************
   // Sequencer and registers
   // ***************************************************************
   logic                armed_q, armed_d, tm_q, tm_d;
   logic                rec_act_q, rec_act_d, post_run_q, post_run_d;
   logic [3:0]          post_cnt_q, post_cnt_d, post_nxt;
   logic [FRAME_W-1:0]  frames_q, frames_d, frame_len_q, frame_len_d;
   logic [8:0]          wbuf_q, wbuf_d, slv_d;
   nrzw_force_s         force_q, force_d;
   logic                wr_cmd_d, fwd_d, recp_d, nreq_d, lrc_d, start_d;
   logic [31:0]         rdata_d;
   logic                wb_load, drive_set_pulse, strobe_pulse_gate;
   logic                crc_hit, lrc_hit, busy;

   always_comb begin
      armed_d     = armed_q;
      tm_d        = tm_q;
      rec_act_d   = rec_act_q;
      post_run_d  = post_run_q;
      post_cnt_d  = post_cnt_q;
      frames_d    = frames_q;
      frame_len_d = frame_len_q;
      par_odd_d   = par_odd_q;
      wbuf_d      = wbuf_q;
      crc_d       = crc_q;
      force_d     = force_q;
      wr_cmd_d    = write_cmd;
      fwd_d       = forward_direction_cmd;
      recp_d      = 1'b0;
      nreq_d      = 1'b0;
      lrc_d       = 1'b0;
      start_d     = 1'b0;
      wb_load     = 1'b0;
      rdata_d     = 32'h0000_0000;
      busy        = armed_q | rec_act_q | post_run_q;
      post_nxt    = post_cnt_q + 4'h1;
      crc_hit     = post_run_q && wclk_rise && post_nxt == NRZW_POST_CRC && !tm_q;
      lrc_hit     = post_run_q && wclk_rise && post_nxt == NRZW_POST_LRC;
      strobe_pulse_gate = crc_hit | lrc_hit;
      drive_set_pulse   = run_rise && armed_q;

      if (reg_wr) begin
         unique case (reg_addr)
            NRZW_OFF_CTRL:  par_odd_d = reg_wdata[NRZW_CTRL_ODD_BIT];
            NRZW_OFF_FRAME: frame_len_d = reg_wdata[FRAME_W-1:0];
            NRZW_OFF_FUNC: begin
               if (!busy && (reg_wdata[7:0] == NRZW_FN_WRITE_MARK ||
                   (reg_wdata[7:0] == NRZW_FN_WRITE_DATA && frame_len_q != '0))) begin
                  armed_d  = 1'b1;
                  wr_cmd_d = 1'b1;
                  fwd_d    = 1'b1;
                  tm_d     = reg_wdata[7:0] == NRZW_FN_WRITE_MARK;
               end
            end
            default: ;
         endcase
      end

      if (reg_rd) begin
         unique case (reg_addr)
            NRZW_OFF_CTRL:   rdata_d = {31'h0, par_odd_q};
            NRZW_OFF_FRAME:  rdata_d = 32'(frame_len_q);
            NRZW_OFF_STATUS: rdata_d = {24'h0, post_cnt_q, post_run_q, rec_act_q,
                                        tm_q, armed_q};
            default:         rdata_d = 32'h0000_0000;
         endcase
      end

      if (drive_set_pulse) begin
         armed_d   = 1'b0;
         rec_act_d = 1'b1;
         start_d   = 1'b1;
         frames_d  = frame_len_q;
         crc_d     = 8'h00;
         if (tm_q) begin
            wbuf_d  = 9'h000;
            force_d = 3'b111;
         end
      end else if (wclk_rise && rec_act_q) begin
         wb_load = 1'b1;
         recp_d  = 1'b1;
         if (!tm_q) begin
            nreq_d   = 1'b1;
            wbuf_d   = data_char;
            crc_d    = crc_step(crc_q, assembled_write_char);
            frames_d = frames_q - 1'b1;
         end
         if (tm_q || frames_q == FRAME_W'(1)) begin
            rec_act_d  = 1'b0;
            post_run_d = 1'b1;
            post_cnt_d = NRZW_POST_PRESET;
         end
      end else if (wclk_rise && post_run_q) begin
         post_cnt_d = post_nxt;
         if (strobe_pulse_gate) begin
            wb_load = 1'b1;
            recp_d  = 1'b1;
         end
         if (crc_hit) begin
            wbuf_d = crc_char;
         end
         if (lrc_hit) begin
            wbuf_d  = 9'h000;
            force_d = 3'b000;
            lrc_d   = 1'b1;
         end
         if (post_nxt == NRZW_POST_STOP) begin
            post_run_d = 1'b0;
            tm_d       = 1'b0;
            wr_cmd_d   = 1'b0;
            fwd_d      = 1'b0;
         end
      end

      slv_d = wbuf_d
            | (force_d.mark_force_main           ? NRZW_FORCE_MAIN   : 9'h000)
            | (force_d.mark_force_seven_track_hi ? NRZW_FORCE_SEV_HI : 9'h000)
            | (force_d.mark_force_seven_track_lo ? NRZW_FORCE_SEV_LO : 9'h000);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         armed_q                   <= 1'b0;
         tm_q                      <= 1'b0;
         rec_act_q                 <= 1'b0;
         post_run_q                <= 1'b0;
         post_cnt_q                <= NRZW_POST_STOP;
         frames_q                  <= '0;
         frame_len_q               <= '0;
         par_odd_q                 <= NRZW_CTRL_ODD_RST;
         wbuf_q                    <= 9'h000;
         crc_q                     <= 8'h00;
         force_q                   <= 3'b000;
         slave_write_lines         <= 9'h000;
         write_cmd                 <= 1'b0;
         forward_direction_cmd     <= 1'b0;
         record_pulse              <= 1'b0;
         next_char_request         <= 1'b0;
         longitudinal_check_strobe <= 1'b0;
         transport_start_pulse     <= 1'b0;
         reg_rdata                 <= 32'h0000_0000;
      end else begin
         armed_q                   <= armed_d;
         tm_q                      <= tm_d;
         rec_act_q                 <= rec_act_d;
         post_run_q                <= post_run_d;
         post_cnt_q                <= post_cnt_d;
         frames_q                  <= frames_d;
         frame_len_q               <= frame_len_d;
         par_odd_q                 <= par_odd_d;
         wbuf_q                    <= wbuf_d;
         crc_q                     <= crc_d;
         force_q                   <= force_d;
         slave_write_lines         <= slv_d;
         write_cmd                 <= wr_cmd_d;
         forward_direction_cmd     <= fwd_d;
         record_pulse              <= recp_d;
         next_char_request         <= nreq_d;
         longitudinal_check_strobe <= lrc_d;
         transport_start_pulse     <= start_d;
         reg_rdata                 <= rdata_d;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_PARITY: assert property (wb_load && rec_act_q && !tm_q |=>
      (^slave_write_lines) == $past(par_odd_q)) else $error("vertical parity wrong");
   AST_LOAD_DATA: assert property (wb_load && rec_act_q && !tm_q |=>
      slave_write_lines == $past(data_char)) else $error("buffer missed character");
   AST_CMDS: assert property (armed_q |-> write_cmd && forward_direction_cmd)
      else $error("commands absent while armed");
   AST_START: assert property (drive_set_pulse |=> transport_start_pulse && rec_act_q
      ##1 !transport_start_pulse) else $error("drive set sequence wrong");
   AST_CHAR_PULSES: assert property (wclk_rise && rec_act_q && !tm_q |=>
      record_pulse && next_char_request) else $error("character pulses missing");
   AST_IDLE_QUIET: assert property (!rec_act_q && !post_run_q |=> !record_pulse)
      else $error("record pulse while idle");
   AST_PRESET: assert property ($fell(rec_act_q) |-> post_run_q &&
      post_cnt_q == NRZW_POST_PRESET) else $error("post counter not preset");
   AST_CRC_SLOT: assert property (post_run_q && wclk_rise && post_cnt_q == 4'hA && !tm_q
      |=> record_pulse && slave_write_lines == $past(crc_char)) else $error("check slot");
   AST_LRC_SLOT: assert property (post_run_q && wclk_rise && post_cnt_q == 4'hE
      |=> record_pulse && longitudinal_check_strobe && slave_write_lines == 9'h000)
      else $error("longitudinal slot wrong");
   AST_STOP: assert property (post_run_q && wclk_rise && post_cnt_q == 4'hF
      |=> !post_run_q && post_cnt_q == 4'h0 && !write_cmd) else $error("counter kept going");
   AST_TM_CHAR: assert property (wb_load && rec_act_q && tm_q
      |=> slave_write_lines == NRZW_TM_CHAR) else $error("tape mark not forced");
   AST_TM_NO_CRC: assert property (tm_q && post_run_q && wclk_rise && post_cnt_q == 4'hA
      |=> !record_pulse) else $error("check character after mark");

   COV_DATA_CRC: cover property (crc_hit);
   COV_LRC:      cover property (lrc_hit && !tm_q);
   COV_TM_LRC:   cover property (lrc_hit && tm_q);

endmodule

// ==== verif/nrzw_transport_model.sv ====
/*
 * Behavioural tape transport on the formatter's slave bus.
 * Assumes the bench's 20 MHz core clock; write clock period 400 ns.
 */
module nrzw_transport_model #(
   parameter int ACCEL = 24,
   parameter int SKEW  = 2
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Slave bus from formatter
   input  wire logic [8:0] slave_write_lines,
   input  wire logic       record_pulse,
   input  wire logic       write_cmd,
   input  wire logic       transport_start_pulse,
   input  wire logic       longitudinal_check_strobe,
   // Back to formatter and bench
   output logic            transport_write_clock,
   output logic [8:0]      deskew
);
   timeunit 1ns;
   timeprecision 1ns;
   logic            gate_q;
   logic            cmd_q;
   logic            lrc_mode_q;
   logic [8:0]      held_q;
   logic [SKEW:0]   skew_q;
   int              accel_q;

   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         gate_q     <= 1'b0;
         cmd_q      <= 1'b0;
         lrc_mode_q <= 1'b0;
         held_q     <= 9'h000;
         skew_q     <= '0;
         accel_q    <= 0;
         deskew     <= 9'h000;
      end else begin
         cmd_q  <= write_cmd;
         skew_q <= {skew_q[SKEW-1:0], record_pulse};
         if (transport_start_pulse) begin
            gate_q  <= 1'b1;
            accel_q <= ACCEL;
         end else if (cmd_q && !write_cmd) begin
            gate_q <= 1'b0;
         end else if (accel_q > 0) begin
            accel_q <= accel_q - 1;
         end
         if (record_pulse) begin
            held_q     <= slave_write_lines;
            lrc_mode_q <= longitudinal_check_strobe;
         end
         if (!gate_q) begin
            deskew <= 9'h000;
         end else if (skew_q[SKEW]) begin
            deskew <= lrc_mode_q ? held_q : deskew ^ held_q;
         end
      end
   end

   // Free of core clock phase; idles low outside records
   initial begin
      transport_write_clock = 1'b0;
      #17;
      forever begin
         #200;
         transport_write_clock = (gate_q && accel_q == 0) ? ~transport_write_clock : 1'b0;
      end
   end
endmodule

// ==== verif/nrzw_formatter_tb.sv ====
/*
 * Self-checking bench for the NRZ write formatter.
 * Assumes the transport model drives the write clock.
 */
module nrzw_formatter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import nrzw_pkg::*;
   logic core_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, run = 0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, st;
   logic [7:0]  assembled_write_char = 8'h00;
   logic next_char_request, transport_write_clock, record_pulse, write_cmd;
   logic forward_direction_cmd, transport_start_pulse, longitudinal_check_strobe, wclk_q = 0;
   logic [8:0]  slave_write_lines, deskew;
   logic [10:0] ev[$];
   logic [8:0]  expq[$];
   logic [7:0]  chars[$];
   int at[$];
   int error_cnt = 0, n_compared = 0, seed = 32'h6f2d, cyc = 0, rises = 0, k, starts = 0;

   always #25 core_clk = ~core_clk;

   nrzw_formatter #(.FRAME_W(16)) DUT (
      .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .assembled_write_char(assembled_write_char), .next_char_request(next_char_request),
      .run(run), .transport_write_clock(transport_write_clock),
      .slave_write_lines(slave_write_lines), .record_pulse(record_pulse),
      .write_cmd(write_cmd), .forward_direction_cmd(forward_direction_cmd),
      .transport_start_pulse(transport_start_pulse),
      .longitudinal_check_strobe(longitudinal_check_strobe));

   nrzw_transport_model TP (
      .core_clk(core_clk), .reset(reset), .slave_write_lines(slave_write_lines),
      .record_pulse(record_pulse), .write_cmd(write_cmd),
      .transport_start_pulse(transport_start_pulse),
      .longitudinal_check_strobe(longitudinal_check_strobe),
      .transport_write_clock(transport_write_clock), .deskew(deskew));

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   function automatic logic par(logic [7:0] d, logic odd);
      return ^d ^ odd;
   endfunction

   function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      return x[7] ? ((x << 1) ^ NRZW_CRC_POLY) : (x << 1);
   endfunction

   // Monitor: log every character slot with the write clock rise it belongs to
   always @(posedge core_clk) begin
      cyc++;
      wclk_q <= transport_write_clock;
      if (transport_write_clock && !wclk_q)
         rises++;
      if (transport_start_pulse)
         starts++;
      if (record_pulse) begin
         ev.push_back({longitudinal_check_strobe, next_char_request, slave_write_lines});
         at.push_back(rises);
      end
      if (next_char_request && chars.size() > 0)
         assembled_write_char <= chars.pop_front();
      if (cyc > 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic record(int n, logic odd, logic mark, logic [7:0] c0);
      logic [7:0] c;
      logic [7:0] crc;
      int i;
      ev.delete();
      at.delete();
      expq.delete();
      rises = 0;
      starts = 0;
      crc = 8'h00;
      wr(NRZW_OFF_CTRL, {31'h0, odd});
      wr(NRZW_OFF_FRAME, n);
      wr(NRZW_OFF_FUNC, {24'h0, mark ? NRZW_FN_WRITE_MARK : NRZW_FN_WRITE_DATA});
      if (!mark) begin
         #1 check("write_cmd", write_cmd, 1);
         check("forward", forward_direction_cmd, 1);
      end
      for (i = 0; i < n; i++) begin
         c = (i == 0) ? c0 : 8'($random(seed));
         chars.push_back(c);
         expq.push_back({par(c, odd), c});
         crc = crc_step(crc, c);
      end
      if (mark) begin
         expq.delete();
         expq.push_back(NRZW_TM_CHAR);
      end else
         expq.push_back({par(crc, odd), crc});
      expq.push_back(9'h000);
      @(posedge core_clk);
      assembled_write_char <= chars.pop_front();
      run <= 1'b1;
      for (i = 0; i < 300; i++) begin
         rd(NRZW_OFF_STATUS, st);
         if (st[7:0] == 8'h00)
            break;
      end
      @(posedge core_clk);
      run <= 1'b0;
      check("start", starts, 1);
      check("slots", ev.size(), expq.size());
      for (i = 0; i < ev.size() && i < expq.size(); i++) begin
         check("char", ev[i][8:0], expq[i]);
         check("request", ev[i][9], i < n && !mark);
         check("lrc", ev[i][10], i == expq.size() - 1);
         check("slot", at[i], i < n ? i + 1 : (i == expq.size() - 1 ? n + 7 : n + 3));
      end
      check("status", st[7:0], 0);
      check("write_cmd", write_cmd, 0);
      check("forward end", forward_direction_cmd, 0);
      check("deskew", deskew, 0);
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(NRZW_OFF_CTRL, st);
      check("ctrl", st, {31'h0, NRZW_CTRL_ODD_RST});
      rd(4'h2, st);
      check("unmapped", st, 0);
      wr(NRZW_OFF_FRAME, 0);
      wr(NRZW_OFF_FUNC, {24'h0, NRZW_FN_WRITE_DATA});
      rd(NRZW_OFF_STATUS, st);
      check("refused", st[0], 0);
      wr(NRZW_OFF_FRAME, 2);
      wr(NRZW_OFF_FUNC, 32'h0000_0003);
      rd(NRZW_OFF_STATUS, st);
      check("bad code", st[0], 0);
      record(1, 1'b1, 1'b0, 8'h00);
      record(4, 1'b0, 1'b0, 8'hFF);
      for (k = 0; k < 3; k++)
         record(1 + ($unsigned($random(seed)) % 5), k[0], 1'b0, 8'($random(seed)));
      record(1, 1'b0, 1'b1, 8'h00);
      wr(NRZW_OFF_FRAME, 3);
      wr(NRZW_OFF_FUNC, {24'h0, NRZW_FN_WRITE_DATA});
      rises = 0;
      run <= 1'b1;
      for (k = 0; k < 300 && rises < 2; k++)
         @(posedge core_clk);
      wr(NRZW_OFF_FUNC, {24'h0, NRZW_FN_WRITE_MARK});
      rd(NRZW_OFF_STATUS, st);
      check("busy", st[3:2] != 2'b00, 1'b1);
      check("busy refused", st[1], 0);
      @(posedge core_clk);
      reset <= 1'b1;
      run   <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      ev.delete();
      repeat (100) @(posedge core_clk);
      check("after reset", ev.size(), 0);
      check("write_cmd", write_cmd, 0);
      rd(NRZW_OFF_STATUS, st);
      check("status after reset", st[7:0], 0);
      rd(NRZW_OFF_CTRL, st);
      check("ctrl after reset", st, {31'h0, NRZW_CTRL_ODD_RST});
      wrap_up();
   end
endmodule
